// file: verif/lcd_glass_panel.sv
// Purpose: glass panel model, tells which segments light
// Assumes: drive levels per phase, bias stage ignored
// Notes: a segment lights against any active backplane
`timescale 1ns/100ps
module lcd_glass_panel (
    // pins seen by the glass
    input wire logic [63:0] pin_function_enable,
    input wire logic [63:0] backplane_select,
    input wire logic [63:0] pin_drive_on,
    // lit frontplane segments
    output logic [63:0] seg_lit
);
    logic [63:0] bp_act;
    logic [63:0] fp_on;
    // backplanes active in this phase
    assign bp_act = pin_function_enable & backplane_select
        & pin_drive_on;
    // frontplanes driven on
    assign fp_on = pin_function_enable & ~backplane_select
        & pin_drive_on;
    assign seg_lit = (|bp_act) ? fp_on : 64'h0;
endmodule

// file: verif/lcd_phase_props.sv
// Purpose: port-level checks of the segment lcd phase driver
// Assumes: one pclk domain, presetn active low
// Notes: bound to the design from the bench top file
`timescale 1ns/100ps
module lcd_phase_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // lcd side
    input wire logic crystal_osc_output,
    input wire logic alt_clock,
    input wire logic [63:0] pin_function_enable,
    input wire logic [63:0] backplane_select,
    input wire logic [63:0] pin_drive_on,
    input wire logic [2:0] phase,
    input wire logic frame_start
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ================================================
    // bus answers
    a_ready_one_wait: assert property
        ($rose(psel && penable) |=> pready) else $error("pready late");
    a_ready_pulse: assert property
        (pready |=> !pready) else $error("pready too long");
    a_err_with_ready: assert property
        (pslverr |-> pready) else $error("pslverr alone");
    a_wave_mapped: assert property (
        pready && paddr[11:8] == 4'h1 |-> !pslverr) else $error("wave err");
    a_hole_refused: assert property
        (pready && paddr == 12'h018 |-> pslverr) else $error("no err");
    a_rdata_hold: assert property
        (!pready |-> $stable(prdata)) else $error("prdata moved");
    // ================================================
    // pins and sequencer
    a_drive_needs_fn: assert property (
        (pin_drive_on & ~(pin_function_enable
        | $past(pin_function_enable))) == 64'h0) else $error("stray drive");
    a_phase_step: assert property (
        $changed(phase) |-> phase == $past(phase) + 3'h1 || phase == 3'h0)
        else $error("phase skipped");
    a_frame_pulse: assert property (
        frame_start |=> !frame_start) else $error("frame pulse long");
    a_frame_at_a: assert property (
        frame_start |-> ##[0:1] phase == 3'h0) else $error("frame not at a");
    // main scenarios
    c_frame: cover property (frame_start);
    c_refused: cover property (pslverr);
    c_phase_h: cover property (phase == 3'h7);
endmodule

// file: verif/segment_lcd_phase_driver_bench.sv
// Purpose: self-checking bench of the segment lcd phase driver
// Assumes: fast toggling lcd clock sources shorten the frames
// Notes: register readback first, then mode rows, then blank and disable by hand
`timescale 1ns/100ps
module segment_lcd_phase_driver_bench;
    import lcd_phase_pkg::*;
    typedef struct {
        logic [2:0] duty;
        logic [2:0] pre;
        logic src;
        int span;
    } row_t;
    localparam logic [7:0] fp_wave = 8'ha5;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crystal_osc_output = 0;
    logic alt_clock = 0;
    logic [1:0] alt_q = 2'h0;
    logic [63:0] pin_function_enable;
    logic [63:0] backplane_select;
    logic [63:0] pin_drive_on;
    logic [63:0] seg_lit;
    logic [2:0] phase;
    logic [2:0] prev_q = 3'h0;
    logic [2:0] max_ph = 3'h0;
    logic frame_start;
    logic chk = 0;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int last_fs = 0;
    int span = 0;
    int nfs = 0;
    // duty, prescale, source, frame span in pclk cycles; prescales keep
    // the frame rate at a nominal lcd clock within about 12.8 to 34.1 Hz
    row_t rows [6] = '{'{3'h0, 3'h3, 1'b0, 4096},
        '{3'h2, 3'h1, 1'b0, 1920}, '{3'h3, 3'h1, 1'b0, 2048},
        '{3'h7, 3'h4, 1'b0, 5120}, '{3'h1, 3'h1, 1'b1, 4096},
        '{3'h5, 3'h2, 1'b0, 3456}};
    always #10 pclk = ~pclk;
    // crystal toggles each cycle, alternate every two
    always @(posedge pclk) begin
        crystal_osc_output <= ~crystal_osc_output;
        alt_q <= alt_q + 2'h1;
        alt_clock <= alt_q[1];
    end
    segment_lcd_phase_driver uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_osc_output(crystal_osc_output),
        .alt_clock(alt_clock), .pin_function_enable(pin_function_enable),
        .backplane_select(backplane_select), .pin_drive_on(pin_drive_on),
        .phase(phase), .frame_start(frame_start));
    lcd_glass_panel panel (.pin_function_enable(pin_function_enable),
        .backplane_select(backplane_select), .pin_drive_on(pin_drive_on),
        .seg_lit(seg_lit));
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic test_done;
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // frame spacing, deepest phase and pin levels per phase
    always @(posedge pclk) begin
        cyc++;
        if (frame_start === 1'b1) begin
            span = cyc - last_fs;
            last_fs = cyc;
            nfs++;
        end
        if (chk && phase === prev_q) begin
            if (phase > max_ph) max_ph = phase;
            check("drive", pin_drive_on[31:0],
                {23'h0, fp_wave[phase], 8'h01 << phase});
            check("lit", seg_lit[31:0],
                {23'h0, fp_wave[phase], 8'h00});
        end
        prev_q = phase;
    end
    initial begin
        #1500000;
        n_mismatch++;
        test_done();
    end
    initial begin
        logic [11:0] ra [6];
        logic [31:0] rw [6];
        logic [31:0] rx [6];
        int k;
        ra = '{12'h008, 12'h00c, 12'h010, 12'h014, 12'h1fc, 12'h004};
        rw = '{32'h1ff, 32'h80000001, 32'hff, 32'h80000001, 32'h3a5, '1};
        rx = '{32'h1ff, 32'h80000001, 32'hff, 32'h80000001, 32'ha5, 0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, main_control_off, 32'h0);
        check("ctl reset", rd, ctl_reset);
        apb(1'b0, 12'h104, 32'h0);
        check("wave reset", rd, 32'h0);
        for (k = 0; k < 6; k++) begin
            apb(1'b1, ra[k], rw[k]);
            apb(1'b0, ra[k], 32'h0);
            check("readback", rd, rx[k]);
        end
        check("bp hi", backplane_select[63:32], 32'h0);
        check("bp lo", backplane_select[31:0], 32'h0);
        check("fn off", pin_function_enable[31:0], 32'h0);
        apb(1'b1, 12'h018, 32'h1);
        check("hole err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h014, 32'h0);
        for (k = 0; k < 8; k++) begin
            apb(1'b1, wave_base_off + 12'(4 * k), 32'h1 << k);
        end
        apb(1'b1, 12'h120, {24'h0, fp_wave});
        foreach (rows[i]) begin
            rw[0] = {21'h0, rows[i].pre, 1'b0, rows[i].duty, 1'b0,
                rows[i].src, 2'b00};
            apb(1'b1, main_control_off, rw[0]);
            apb(1'b1, main_control_off, rw[0] | 32'h1);
            repeat (4) @(posedge pclk);
            chk = 1'b1;
            max_ph = 3'h0;
            nfs = 0;
            for (k = 0; k < 20000 && nfs < 2; k++) @(posedge pclk);
            chk = 1'b0;
            check("span", span, rows[i].span);
            check("duty", {29'h0, max_ph}, {29'h0, rows[i].duty});
            check("fn on", pin_function_enable[31:0], 32'h1ff);
            check("bp on", backplane_select[31:0], 32'hff);
            check("frames", nfs, 32'h2);
            apb(1'b1, main_control_off, rw[0]);
        end
        apb(1'b1, main_control_off, 32'h103);
        repeat (4) @(posedge pclk);
        check("blank", pin_drive_on[31:0], 32'h0);
        check("blank lit", seg_lit[31:0], 32'h0);
        check("hi drive", pin_drive_on[63:32], 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        check("rst fn", pin_function_enable[31:0], 32'h0);
        check("rst phase", {29'h0, phase}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, main_control_off, 32'h0);
        repeat (2) @(posedge pclk);
        check("fn off", pin_function_enable[31:0], 32'h0);
        test_done();
    end
endmodule
bind segment_lcd_phase_driver lcd_phase_props u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_osc_output(crystal_osc_output),
    .alt_clock(alt_clock), .pin_function_enable(pin_function_enable),
    .backplane_select(backplane_select), .pin_drive_on(pin_drive_on),
    .phase(phase), .frame_start(frame_start));

// file: verilog/lcd_base_divider.sv
// Purpose: counts lcd clock edges and emits the base clock enable
// Assumes: step is a one-cycle pulse per lcd clock edge
// Notes: clear restarts the count; terminal may change between frames

`timescale 1ns/100ps

module lcd_base_divider (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clear,
    input wire logic step,
    input wire logic [lcd_phase_pkg::div_w-1:0] terminal,
    // output
    output logic tick
);
    import lcd_phase_pkg::*;

    logic [div_w-1:0] count_q;

    // count lcd clock edges up to terminal then wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            tick <= 1'b0;
        end else if (clear) begin
            count_q <= '0;
            tick <= 1'b0;
        end else if (step) begin
            if (count_q >= terminal) begin
                count_q <= '0;
                tick <= 1'b1;
            end else begin
                count_q <= count_q + 13'h0001;
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule

// file: verilog/lcd_phase_pkg.sv
// Purpose: constants, types and register map of the segment lcd phase driver
// Assumes: apb slave on pclk, 32-bit data, 12-bit byte address
// Notes: waveform words sit at wave_base + 4 * pin
//
// What this block does
// - A pin drives lcd function only while its pin enable and the global enable are both set.
// - A pin whose backplane select bit is set is driven as a backplane, else as a frontplane.
// - Each pin has a waveform register: segment data per phase, or the active phase of a backplane.
// - A zero waveform bit on a frontplane drives that phase's segment off.
// - A one in waveform bit y of a frontplane turns on its segment against the phase y backplane.
// - In blank display mode the waveform registers are ignored and all pins drive inactive.
// - A backplane pin is active in whichever phases its own waveform register marks.
// - Duty field n selects n+1 backplanes, phases A onward used in order.
// - The enabled phases are output in sequence, the whole sequence repeating once per frame.
// - The source bit picks the lcd clock: zero the crystal oscillator, one the alternate clock.
// - The base clock runs at frame rate times backplane count, one phase per base period.
// - The frame rate depends on the prescale field and a per-duty factor 16,8,5,4,3,3,2,2.
// - The divider is sized for a nominal 32.768 kHz lcd clock.

package lcd_phase_pkg;

    // ====================================================================
    // sizes
    localparam int unsigned num_pins = 64;
    localparam int unsigned num_phases = 8;
    localparam int unsigned addr_w = 12;
    localparam int unsigned div_w = 13;

    // ====================================================================
    // register map (byte addresses)
    localparam logic [11:0] main_control_off = 12'h000;
    localparam logic [11:0] status_off = 12'h004;
    localparam logic [11:0] pin_enable_lo_off = 12'h008;
    localparam logic [11:0] pin_enable_hi_off = 12'h00c;
    localparam logic [11:0] backplane_select_lo_off = 12'h010;
    localparam logic [11:0] backplane_select_hi_off = 12'h014;
    localparam logic [11:0] wave_base_off = 12'h100;
    localparam logic [1:0] wave_page = 2'h1; // addr[9:8] of waveform words

    // ====================================================================
    // main control field positions and reset
    localparam int unsigned ctl_enable_bit = 0;
    localparam int unsigned ctl_blank_bit = 1;
    localparam int unsigned ctl_source_bit = 2;
    localparam int unsigned ctl_duty_lsb = 4;
    localparam int unsigned ctl_prescale_lsb = 8;
    localparam logic [31:0] ctl_reset = 32'h0000_0000;

    // status field positions
    localparam int unsigned st_phase_lsb = 0;
    localparam int unsigned st_running_bit = 4;

    // ====================================================================
    // timing: base clock = lcd clock / ((prescale+1) * 32 * factor)
    localparam real lcd_clock_khz = 32.768; // nominal lcd clock
    localparam logic [div_w-1:0] base_div_fixed = 13'h0020; // 32

    // per-duty factor, index = duty field
    localparam logic [4:0] duty_factor [num_phases] = '{
        5'h10, 5'h08, 5'h05, 5'h04, 5'h03, 5'h03, 5'h02, 5'h02
    };

    // ====================================================================
    // main control register as a carrier
    typedef struct packed {
        logic [2:0] frame_prescale_field;
        logic [2:0] duty;
        logic source_alt;
        logic blank_display;
        logic module_enable;
    } lcd_ctrl_t;

    typedef enum logic [0:0] {seq_idle, seq_run} seq_state_t;

endpackage

// file: verilog/segment_lcd_phase_driver.sv
// Purpose: segment lcd pin enables, backplane select, waveform store and
//          backplane phase sequencer, reached over apb
// Assumes: lcd clock source inputs are synchronous to pclk and much slower
// Notes: one wait state on every apb access; pins drive levels only, the
//        analog bias stage sits outside this block; control at 0x000,
//        status at 0x004, pin enable at 0x008/0x00c, backplane select at
//        0x010/0x014, waveform of pin x at 0x100 + 4 * x; settings written
//        while enabled act at once, so configure first, then enable

`timescale 1ns/100ps

module segment_lcd_phase_driver (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lcd_phase_pkg::addr_w-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lcd clock sources
    input wire logic crystal_osc_output,
    input wire logic alt_clock,
    // lcd pins
    output logic [lcd_phase_pkg::num_pins-1:0] pin_function_enable,
    output logic [lcd_phase_pkg::num_pins-1:0] backplane_select,
    output logic [lcd_phase_pkg::num_pins-1:0] pin_drive_on,
    // sequencer state
    output logic [2:0] phase,
    output logic frame_start
);
    import lcd_phase_pkg::*;

    // ====================================================================
    // registers
    lcd_ctrl_t main_control_reg_q;
    logic [num_pins-1:0] pin_enable_reg_q;
    logic [num_pins-1:0] backplane_select_reg_q;
    logic [7:0] pin_waveform_reg_q [num_pins];

    // sequencer
    seq_state_t seq_q;
    logic [2:0] phase_q;
    logic frame_start_q;

    // lcd clock edge detect
    logic osc_q;
    logic alt_q;
    logic panel_clock_q;
    logic panel_clock_d;
    logic panel_step;
    logic base_tick;
    logic [div_w-1:0] div_terminal;
    logic div_clear;
    logic [4:0] base_factor;
    logic running;

    // apb
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic wave_hit;
    logic [5:0] wave_idx;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic wr_ctl;

    // pin outputs
    logic [num_pins-1:0] pin_func_q;
    logic [num_pins-1:0] pin_bp_q;
    logic [num_pins-1:0] pin_drive_q;
    logic [num_pins-1:0] pin_live;

    // ====================================================================
    // apb decode
    assign access = psel && penable;
    // a write lands on the edge that samples pready high; a master that
    // drops its request before then writes nothing
    assign wr_fire = access && pready_q && pwrite;
    assign wr_ctl = wr_fire && (paddr == main_control_off);
    assign rd_fire = access && !pready_q && !pwrite;
    assign wave_hit = (paddr[9:8] == wave_page) && (paddr[11:10] == 2'h0)
                      && (paddr[1:0] == 2'h0);
    // waveform words sit on page 1, one aligned word per pin
    assign wave_idx = paddr[7:2];

    // read mux, unmapped addresses flagged
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        if (wave_hit) begin
            rd_data = {24'h000000, pin_waveform_reg_q[wave_idx]};
        end else begin
            case (paddr)
                main_control_off: begin
                    rd_data[ctl_enable_bit] = main_control_reg_q.module_enable;
                    rd_data[ctl_blank_bit] = main_control_reg_q.blank_display;
                    rd_data[ctl_source_bit] = main_control_reg_q.source_alt;
                    rd_data[ctl_duty_lsb +: 3] = main_control_reg_q.duty;
                    rd_data[ctl_prescale_lsb +: 3] =
                        main_control_reg_q.frame_prescale_field;
                end
                status_off: begin
                    rd_data[st_phase_lsb +: 3] = phase_q;
                    rd_data[st_running_bit] = running;
                end
                // pins 0 to 31 in the low word, 32 to 63 in the high word
                pin_enable_lo_off: rd_data = pin_enable_reg_q[31:0];
                pin_enable_hi_off: rd_data = pin_enable_reg_q[63:32];
                backplane_select_lo_off:
                    rd_data = backplane_select_reg_q[31:0];
                backplane_select_hi_off:
                    rd_data = backplane_select_reg_q[63:32];
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // ready after one wait state, high for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access && !pready_q;
        end
    end

    // error flag rides with ready on an unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= access && !pready_q && !rd_ok;
        end
    end

    // read data captured with ready, held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_fire) begin
            prdata_q <= rd_data;
        end
    end

    // main control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_control_reg_q <= lcd_ctrl_t'(ctl_reset[8:0]);
        end else if (wr_ctl) begin
            main_control_reg_q.module_enable <= pwdata[ctl_enable_bit];
            main_control_reg_q.blank_display <= pwdata[ctl_blank_bit];
            main_control_reg_q.source_alt <= pwdata[ctl_source_bit];
            main_control_reg_q.duty <= pwdata[ctl_duty_lsb +: 3];
            main_control_reg_q.frame_prescale_field <=
                pwdata[ctl_prescale_lsb +: 3];
        end
    end

    // pin enable and backplane select writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_enable_reg_q <= '0;
            backplane_select_reg_q <= '0;
        end else if (wr_fire) begin
            case (paddr)
                pin_enable_lo_off: pin_enable_reg_q[31:0] <= pwdata;
                pin_enable_hi_off: pin_enable_reg_q[63:32] <= pwdata;
                backplane_select_lo_off:
                    backplane_select_reg_q[31:0] <= pwdata;
                backplane_select_hi_off:
                    backplane_select_reg_q[63:32] <= pwdata;
                default: ;
            endcase
        end
    end

    // waveform store, one byte per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < num_pins; i++) begin
                pin_waveform_reg_q[i] <= 8'h00;
            end
        end else if (wr_fire && wave_hit) begin
            pin_waveform_reg_q[wave_idx] <= pwdata[7:0];
        end
    end

    // ====================================================================
    // lcd clock: sample both sources, select, detect rising edge
    always_comb begin
        if (main_control_reg_q.source_alt) begin
            panel_clock_d = alt_q;
        end else begin
            panel_clock_d = osc_q;
        end
    end

    // sample both sources every pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q <= 1'b0;
            alt_q <= 1'b0;
        end else begin
            osc_q <= crystal_osc_output;
            alt_q <= alt_clock;
        end
    end

    // last selected level; resets low like an idle source, so no false
    // edge follows reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_clock_q <= 1'b0;
        end else begin
            panel_clock_q <= panel_clock_d;
        end
    end

    assign panel_step = panel_clock_d && !panel_clock_q;

    // per-duty factor of the selected duty
    assign base_factor = duty_factor[main_control_reg_q.duty];

    // base period in lcd clocks: (prescale+1) * 32 * factor, minus one
    // fits 13 bits: 8 * 32 * 16 = 4096 at a 32.768 kHz lcd clock
    assign div_terminal = div_w'(
        ({10'h000, main_control_reg_q.frame_prescale_field} + 13'h0001)
        * base_div_fixed
        * {8'h00, base_factor}
        - 13'h0001);

    // divider held cleared while idle, so a frame starts on a full count
    assign running = (seq_q == seq_run);
    assign div_clear = !running;

    lcd_base_divider u_base_div (
        .pclk(pclk),
        .presetn(presetn),
        .clear(div_clear),
        .step(panel_step),
        .terminal(div_terminal),
        .tick(base_tick)
    );

    // ====================================================================
    // phase sequencer, runs while the module is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= seq_idle;
            phase_q <= 3'h0;
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= 1'b0;
            case (seq_q)
                seq_idle: begin
                    phase_q <= 3'h0;
                    if (main_control_reg_q.module_enable) begin
                        seq_q <= seq_run;
                        frame_start_q <= 1'b1;
                    end
                end
                seq_run: begin
                    if (!main_control_reg_q.module_enable) begin
                        seq_q <= seq_idle;
                        phase_q <= 3'h0;
                    end else if (base_tick) begin
                        // a duty lowered mid-frame wraps at the next tick
                        if (phase_q >= main_control_reg_q.duty) begin
                            phase_q <= 3'h0;
                            frame_start_q <= 1'b1;
                        end else begin
                            phase_q <= phase_q + 3'h1;
                        end
                    end
                end
                default: begin
                    seq_q <= seq_idle;
                    phase_q <= 3'h0;
                end
            endcase
        end
    end

    // ====================================================================
    // pin outputs; backplanes and frontplanes both follow the waveform bit
    // of the current phase, the panel sees the difference
    // pins that carry lcd function: own enable and global enable
    assign pin_live = pin_enable_reg_q
        & {num_pins{main_control_reg_q.module_enable}};

    // lcd function per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_func_q <= '0;
        end else begin
            pin_func_q <= pin_live;
        end
    end

    // backplane role per live pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_bp_q <= '0;
        end else begin
            pin_bp_q <= pin_live & backplane_select_reg_q;
        end
    end

    // zero bit drives off, one bit drives on or active; blank drives off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_drive_q <= '0;
        end else begin
            for (int x = 0; x < num_pins; x++) begin
                pin_drive_q[x] <= pin_live[x]
                    && !main_control_reg_q.blank_display
                    && pin_waveform_reg_q[x][phase_q];
            end
        end
    end

    // outputs, each straight from a flop so pins and bus see no glitch
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_function_enable = pin_func_q;
    assign backplane_select = pin_bp_q;
    assign pin_drive_on = pin_drive_q;
    assign phase = phase_q;
    assign frame_start = frame_start_q;

endmodule
